/* File: logic/dfme_pkg.sv */
/*
 package for the diagnostic fault message encoder: field layout, reset values,
 timing figures. assumes a 125 MHz mclk.
*/
`default_nettype none
package dfme_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] DFME_OFF_CTRL = 8'h00;
	localparam logic [7:0] DFME_OFF_FAULT = 8'h04;
	localparam logic [7:0] DFME_OFF_ADDR = 8'h08;
	localparam logic [7:0] DFME_OFF_STATUS = 8'h0C;
	localparam logic [7:0] DFME_OFF_MSG_LO = 8'h10;
	localparam logic [7:0] DFME_OFF_MSG_HI = 8'h14;
	// ----------------------------------------
	// field values
	// ----------------------------------------
	localparam logic [7:0] DFME_EXT_NONE = 8'hFF;
	localparam logic [7:0] DFME_MSB_ALL = 8'h00;
	localparam logic [7:0] DFME_INST_MAX = 8'hFA;
	localparam logic [18:0] DFME_GENERIC_MAX = 19'h000FF;
	localparam logic [10:0] DFME_UNIV_MAX = 11'h7FF;
	localparam logic [4:0] DFME_FMC_LAST_FIXED = 5'h13;
	localparam logic [4:0] DFME_FMC_NONE = 5'h1F;
	localparam logic [7:0] DFME_OCC_NONE = 8'hFF;
	localparam logic [1:0] DFME_LAMP_ON = 2'h1;
	localparam logic [1:0] DFME_LAMP_OFF = 2'h0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int DFME_CLK_MHZ = 125;
	localparam int DFME_FAST_MS = 100;
	localparam int DFME_SLOW_MS = 1000;
	localparam int DFME_IDLE_MS = 5000;
	localparam int DFME_CYC_PER_MS = DFME_CLK_MHZ * 1000;
	localparam int DFME_FAST_CYC = DFME_FAST_MS * DFME_CYC_PER_MS;
	localparam int DFME_SLOW_CYC = DFME_SLOW_MS * DFME_CYC_PER_MS;
	localparam int DFME_IDLE_CYC = DFME_IDLE_MS * DFME_CYC_PER_MS;
endpackage
`default_nettype wire

/* File: logic/dfme_top.sv */
/*
 diagnostic fault message encoder: software loads a fault over ahb-lite, the
 block assembles the 8-byte message payload and pulses msg_send on schedule.
 assumes a single ahb-lite master and a can transmitter that takes msg_data
 on msg_send when msg_ready is high.
*/
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
//Contract
//- lamp set implies fault number and mode
//- yellow and red lamps independent
//- default source address is 8 bits
//- no extension means extension byte FFh
//- extension never used for address claiming
//- single instance: 19-bit number over three bytes
//- multi instance: 11-bit number plus instance
//- msb 00h all instances, 01h-FAh one
//- mid byte: middle bits or instance
//- low byte bits 7:5 hold number lsbs
//- numbers 00h-FFh reserved for generic faults
//- generic fault on multi instance: single encoding
//- whole-device faults msb 00h, else nonzero
//- whole-device numbers limited to 2048
//- failure mode code universal for all types
//- codes 0..19 are fixed categories
//- 31 not available, 20..30 never sent
//- one message per function or instance
//- per instance or combined report allowed
//- combined report has single status byte
//- active fault repeats every 100..1000 ms
//- no fault: message every 5000 ms idle
`timescale 1ns/1ps
`default_nettype none
module dfme_top
	import dfme_pkg::*;
#(
	parameter int FAST_CYC = DFME_FAST_CYC,
	parameter int SLOW_CYC = DFME_SLOW_CYC,
	parameter int IDLE_CYC = DFME_IDLE_CYC
)(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic other_status_sent,
	input wire logic msg_ready,
	output logic msg_send,
	output logic [63:0] msg_data
);
	import dfme_pkg::*;

	// elaboration guard: the scheduler needs periods of two cycles or more
	if (FAST_CYC < 2 || SLOW_CYC < FAST_CYC || IDLE_CYC < 2)
	begin : g_bad_period
		$error("dfme_top: bad period parameters");
	end

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] ctrl_q;
	logic [31:0] fault_q;
	logic [31:0] addr_q;
	logic [31:0] rdata_d;
	logic [63:0] msg_q;
	logic sent_flag_q;
	logic rej_flag_q;
	logic fault_ok;
	logic take;

	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// capture write address phase
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= take && hwrite;
			wr_addr_q <= haddr;
		end
	end

	// control: bit0 enable, bit1 multi-instance, bit2 fast rate
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			ctrl_q <= 32'h0000_0000;
		else if (wr_pend_q && wr_addr_q == DFME_OFF_CTRL)
			ctrl_q <= {29'h0, hwdata[2:0]};
	end

	// fault: [18:0] number, [23:19] mode, [31:24] instance; lamps in addr reg
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			fault_q <= 32'h0000_0000;
		else if (wr_pend_q && wr_addr_q == DFME_OFF_FAULT)
			fault_q <= hwdata;
	end

	// addr: [7:0] source addr, [15:8] extension, [17:16] yellow/red, [19:18] opstat
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			addr_q <= {24'h0000_00, 8'h00} | {16'h0, DFME_EXT_NONE, 8'h00};
		else if (wr_pend_q && wr_addr_q == DFME_OFF_ADDR)
			addr_q <= {12'h000, hwdata[19:0]};
	end

	// read mux, registered into data phase
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (haddr)
			DFME_OFF_CTRL: rdata_d = ctrl_q;
			DFME_OFF_FAULT: rdata_d = fault_q;
			DFME_OFF_ADDR: rdata_d = addr_q;
			DFME_OFF_STATUS: rdata_d = {29'h0, rej_flag_q, sent_flag_q, fault_ok};
			DFME_OFF_MSG_LO: rdata_d = msg_q[31:0];
			DFME_OFF_MSG_HI: rdata_d = msg_q[63:32];
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// read data held until the next read address phase
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata <= rdata_d;
	end

	// ----------------------------------------
	// payload assembly
	// ----------------------------------------
	logic multi;
	logic lamp_any;
	logic generic;
	logic [18:0] num;
	logic [4:0] fmc;
	logic [7:0] inst;
	logic [7:0] b_msb;
	logic [7:0] b_mid;
	logic [7:0] b_low;
	logic [63:0] msg_d;

	assign multi = ctrl_q[1];
	assign num = fault_q[18:0];
	assign fmc = fault_q[23:19];
	assign inst = fault_q[31:24];
	assign lamp_any = addr_q[16] || addr_q[17];
	assign generic = num <= DFME_GENERIC_MAX;

	// fault legality: reserved modes, instance range, whole-device limit
	always_comb
	begin
		fault_ok = 1'b1;
		if (fmc > DFME_FMC_LAST_FIXED && fmc != DFME_FMC_NONE)
			fault_ok = 1'b0;
		if (multi && !generic && num[10:3] > DFME_INST_MAX)
			fault_ok = 1'b0;
		if (multi && !generic && num[18:11] != 8'h00)
			fault_ok = 1'b0;
	end

	// three fault bytes, by device class
	always_comb
	begin
		if (!lamp_any)
		begin
			b_msb = 8'h00;
			b_mid = 8'h00;
			b_low = {3'b000, DFME_FMC_NONE};
		end
		else if (multi && !generic)
		begin
			b_msb = num[10:3];
			b_mid = inst;
			b_low = {num[2:0], fmc};
		end
		else
		begin
			b_msb = num[18:11];
			b_mid = num[10:3];
			b_low = {num[2:0], fmc};
		end
	end

	// byte 0 status/lamps, 1 source addr, 2..4 fault, 5 count, 6 extension, 7 bank
	assign msg_d = {8'hFF, addr_q[15:8], DFME_OCC_NONE, b_low, b_mid, b_msb,
		addr_q[7:0], addr_q[17] ? DFME_LAMP_ON : DFME_LAMP_OFF,
		addr_q[16] ? DFME_LAMP_ON : DFME_LAMP_OFF, 2'b01, addr_q[19:18]};

	// ----------------------------------------
	// broadcast scheduler
	// ----------------------------------------
	logic [31:0] tick_q;
	logic [31:0] period;
	logic due;
	logic can_send;

	// one message slot per register load; software steps through instances
	assign period = lamp_any ? 32'(ctrl_q[2] ? FAST_CYC : SLOW_CYC)
		: 32'(IDLE_CYC);
	assign due = tick_q >= period - 32'h0000_0001;
	assign can_send = ctrl_q[0] && msg_ready && fault_ok && due;

	// idle count restarts on any other status broadcast
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			tick_q <= 32'h0000_0000;
		else if (can_send || (!lamp_any && other_status_sent) || !ctrl_q[0])
			tick_q <= 32'h0000_0000;
		else if (!due)
			tick_q <= tick_q + 32'h0000_0001;
	end

	// frame strobe and payload, plus a readable copy of the last frame
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			msg_send <= 1'b0;
			msg_q <= 64'h0;
			msg_data <= 64'h0;
		end
		else
		begin
			msg_send <= can_send;
			if (can_send)
			begin
				msg_q <= msg_d;
				msg_data <= msg_d;
			end
		end
	end

	// sticky status: set beats clear by a status write of 1
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			sent_flag_q <= 1'b0;
			rej_flag_q <= 1'b0;
		end
		else
		begin
			sent_flag_q <= can_send ||
				(sent_flag_q && !(wr_pend_q && wr_addr_q == DFME_OFF_STATUS && hwdata[1]));
			rej_flag_q <= (ctrl_q[0] && due && !fault_ok) ||
				(rej_flag_q && !(wr_pend_q && wr_addr_q == DFME_OFF_STATUS && hwdata[2]));
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------

	// cycles since the last frame, saturating; starts high so the first frame passes
	logic [31:0] gap_q;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			gap_q <= 32'hFFFF_FFFF;
		else if (msg_send)
			gap_q <= 32'h0000_0001;
		else if (gap_q != 32'hFFFF_FFFF)
			gap_q <= gap_q + 32'h0000_0001;
	end

	a_lamp_fields: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && (msg_data[6] || msg_data[4]) |->
		msg_data[36:32] == $past(fmc) && msg_data[39:37] == $past(num[2:0]))
		else $error("lamp set without fault fields");
	a_ext_byte: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> msg_data[55:48] == $past(addr_q[15:8]))
		else $error("extension byte wrong");
	a_no_reserved: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && (msg_data[6] || msg_data[4]) |->
		(msg_data[36:32] <= DFME_FMC_LAST_FIXED || msg_data[36:32] == DFME_FMC_NONE))
		else $error("reserved mode sent");
	a_low_split: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && msg_data[6:4] != 3'b000 |-> msg_data[39:37] == $past(num[2:0]))
		else $error("number lsbs misplaced");
	a_inst_range: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && $past(multi && !generic && lamp_any) |-> msg_data[23:16] <= DFME_INST_MAX)
		else $error("instance out of range");
	a_generic_single: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && $past(generic && lamp_any) |-> msg_data[23:16] == 8'h00)
		else $error("generic fault carries instance");
	a_lamps_indep: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> msg_data[7:4] == {1'b0, $past(addr_q[17]), 1'b0, $past(addr_q[16])})
		else $error("lamp bits wrong");
	a_src_addr: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> msg_data[15:8] == $past(addr_q[7:0]))
		else $error("source address wrong");
	a_send_pulse: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |=> !msg_send)
		else $error("back to back sends");
	// msb byte: number top bits, or number bits 10:3 on a multi-instance fault
	a_msb_byte: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && $past(lamp_any) |-> msg_data[23:16] ==
		($past(multi && !generic) ? $past(num[10:3]) : $past(num[18:11])))
		else $error("msb fault byte wrong");
	// mid byte: number middle bits, or the instance on a multi-instance fault
	a_mid_byte: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && $past(lamp_any) |-> msg_data[31:24] ==
		($past(multi && !generic) ? $past(inst) : $past(num[10:3])))
		else $error("mid fault byte wrong");
	// no lamp: empty fault bytes, mode not available
	a_idle_bytes: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && !msg_data[6] && !msg_data[4] |->
		msg_data[39:16] == {3'b000, DFME_FMC_NONE, 16'h0000})
		else $error("idle fault bytes wrong");
	// count, bank and fixed status bits never vary
	a_fixed_bytes: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> msg_data[63:56] == 8'hFF && msg_data[47:40] == DFME_OCC_NONE
		&& msg_data[3:2] == 2'b01)
		else $error("fixed bytes wrong");
	// one operating status field per frame, from the address register
	a_op_status: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> msg_data[1:0] == $past(addr_q[19:18]))
		else $error("operating status wrong");
	// only a legal fault, enabled, with the transmitter ready goes out
	a_send_legal: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> $past(fault_ok && msg_ready && ctrl_q[0]))
		else $error("frame sent while refused");
	// multi-instance numbers above 2047 never leave the block
	a_whole_dev: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send && $past(multi && !generic && lamp_any) |->
		$past(num[18:11]) == 8'h00)
		else $error("whole-device number too large");
	// frames never closer than the period in force
	a_min_period: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> gap_q >= $past(period))
		else $error("frames closer than the period");
	// every frame leaves its mark in the sent flag
	a_sent_sticky: assert property (@(posedge mclk) disable iff (!nrst)
		msg_send |-> sent_flag_q)
		else $error("sent flag missing");
	// a refused due fault is flagged one cycle later
	a_rej_flag: assert property (@(posedge mclk) disable iff (!nrst)
		ctrl_q[0] && due && !fault_ok |=> rej_flag_q)
		else $error("refusal not flagged");
	// a foreign status frame restarts the idle count
	a_idle_restart: assert property (@(posedge mclk) disable iff (!nrst)
		ctrl_q[0] && !lamp_any && other_status_sent |=> tick_q == 32'h0000_0000)
		else $error("idle count not restarted");
	// a disabled encoder stays silent
	a_send_off: assert property (@(posedge mclk) disable iff (!nrst)
		!ctrl_q[0] |=> !msg_send)
		else $error("frame while disabled");

	// main scenarios: fault, both lamps, idle, refusal, multi-instance
	c_fault_send: cover property (@(posedge mclk) disable iff (!nrst) msg_send && msg_data[4]);
	c_both_lamps: cover property (@(posedge mclk) disable iff (!nrst) msg_send && msg_data[6]
		&& msg_data[4]);
	c_idle_send: cover property (@(posedge mclk) disable iff (!nrst) msg_send && !msg_data[6]
		&& !msg_data[4]);
	c_reject: cover property (@(posedge mclk) disable iff (!nrst) rej_flag_q);
	c_multi_send: cover property (@(posedge mclk) disable iff (!nrst) msg_send
		&& $past(multi && !generic));
endmodule // dfme_top
`default_nettype wire

/* File: testbench/dfme_can_sink.sv */
/*
 stand-in for the can transmitter behind msg_send and msg_data.
 assumes one mclk domain; it stalls at random and is busy right after a frame.
*/
`timescale 1ns/1ps
`default_nettype none
module dfme_can_sink (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic msg_send,
	output logic msg_ready
);
	// ----------------------------------------
	// readiness
	// ----------------------------------------
	// busy for a cycle after each frame, and one cycle in four at random,
	// so a due message sometimes has to wait
	always @(posedge mclk)
	begin
		msg_ready <= nrst && !msg_send && ($urandom % 4 != 0);
	end
endmodule // dfme_can_sink
`default_nettype wire

/* File: testbench/testbench.sv */
/*
 self-checking bench for the fault message encoder: ahb-lite register tasks,
 expected frames queued by the driver and checked by a frame watcher.
 assumes short periods handed to the design and the transmitter stand-in.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dfme_pkg::*;
	localparam int FC = 20;
	localparam int SC = 50;
	localparam int IC = 80;
	logic mclk = 0, nrst = 0, hsel = 0, hwrite = 0, oss = 0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic hreadyout, hresp, msg_ready, msg_send;
	logic [63:0] msg_data;
	logic [63:0] expq[$];
	int n_errors = 0, n_checks = 0, n_sent = 0, cyc = 0, last = -1, pc = -1, gmin = 0;
	always #4 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	dfme_top #(.FAST_CYC(FC), .SLOW_CYC(SC), .IDLE_CYC(IC)) dut (.mclk(mclk), .nrst(nrst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .other_status_sent(oss), .msg_ready(msg_ready),
		.msg_send(msg_send), .msg_data(msg_data));
	dfme_can_sink sink (.mclk(mclk), .nrst(nrst), .msg_send(msg_send), .msg_ready(msg_ready));
	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task test_done;
		$display("counts: errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task cmp_msg(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_msg({32'h0, got}, {32'h0, exp});
	endtask
	// ----------------------------------------
	// bus master
	// ----------------------------------------
	// one bounded wait for hready; running out ends the run
	task hold;
		int i;
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50)
		begin
			n_errors++;
			test_done;
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		htrans <= 2'h2;
		hold;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hold;
		q = hrdata;
	endtask
	// byte 0 first: status, lamps, address, three fault bytes, count, extension, bank
	function automatic logic [63:0] mk(input logic y, input logic r, input logic [7:0] b2,
		input logic [7:0] b3, input logic [7:0] b4, input logic [7:0] src,
		input logic [7:0] ext, input logic [1:0] op);
		return {8'hFF, ext, 8'hFF, b4, b3, b2, src, (r ? DFME_LAMP_ON : DFME_LAMP_OFF),
			(y ? DFME_LAMP_ON : DFME_LAMP_OFF), 2'h1, op};
	endfunction
	// ----------------------------------------
	// frame watcher
	// ----------------------------------------
	// a frame with nothing queued, or too early, is a mismatch
	always @(posedge mclk)
	begin
		if (msg_send === 1'b1)
		begin
			n_sent++;
			n_checks++;
			if ((last >= 0 && cyc - last < gmin) || (pc >= 0 && cyc - pc < IC))
			begin
				n_errors++;
				$display("MISMATCH t=%0t gap=%h min=%h", $time, cyc - last, gmin);
			end
			last = cyc;
			if (expq.size() == 0)
				cmp_msg(msg_data, ~msg_data);
			else
				cmp_msg(msg_data, expq.pop_front());
		end
	end
	// ----------------------------------------
	// one fault load, two repeats or a refusal
	// ----------------------------------------
	task scen(input logic mu, input logic fa, input logic y, input logic r,
		input logic [18:0] n, input logic [4:0] m, input logic [7:0] in, input logic legal);
		logic [7:0] src, ext;
		logic [1:0] op;
		logic [63:0] e;
		logic [31:0] q;
		int i, t;
		src = 8'($urandom);
		ext = 8'($urandom);
		op = 2'($urandom);
		bus(1'b1, DFME_OFF_CTRL, 32'h0, q);
		bus(1'b1, DFME_OFF_STATUS, 32'h6, q);
		bus(1'b1, DFME_OFF_FAULT, {in, m, n}, q);
		bus(1'b1, DFME_OFF_ADDR, {12'h0, op, r, y, ext, src}, q);
		if (y | r)
			e = mk(y, r, (mu && n > DFME_GENERIC_MAX) ? n[10:3] : n[18:11],
				(mu && n > DFME_GENERIC_MAX) ? in : n[10:3], {n[2:0], m}, src, ext, op);
		else
			e = mk(1'b0, 1'b0, 8'h00, 8'h00, {3'h0, DFME_FMC_NONE}, src, ext, op);
		if (legal)
		begin
			expq.push_back(e);
			expq.push_back(e);
		end
		gmin = (y | r) ? (fa ? FC : SC) : IC;
		last = -1;
		bus(1'b1, DFME_OFF_CTRL, {29'h0, fa, mu, 1'b1}, q);
		// with no fault, a foreign status frame defers the idle message
		if (!(y | r))
		begin
			repeat (30) @(posedge mclk);
			oss <= 1'b1;
			@(posedge mclk);
			pc = cyc;
			oss <= 1'b0;
		end
		t = n_sent + (legal ? 2 : 0);
		i = 0;
		while ((n_sent < t || !legal) && i < IC + 2 * gmin + 60)
		begin
			@(posedge mclk);
			i++;
		end
		pc = -1;
		if (n_sent < t)
		begin
			n_errors++;
			test_done;
		end
		bus(1'b0, DFME_OFF_STATUS, 32'h0, q);
		cmp_reg({31'h0, q[2]}, {31'h0, ~legal});
		if (legal)
		begin
			bus(1'b0, DFME_OFF_MSG_LO, 32'h0, q);
			cmp_reg(q, e[31:0]);
		end
		bus(1'b1, DFME_OFF_CTRL, 32'h0, q);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] q;
		void'($urandom(78697));
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		bus(1'b0, DFME_OFF_ADDR, 32'h0, q);
		cmp_reg(q, 32'h0000FF00);
		bus(1'b1, 8'h20, 32'hFFFFFFFF, q);
		bus(1'b0, 8'h20, 32'h0, q);
		cmp_reg(q, 32'h0);
		scen(0, 1, 1, 1, 19'(256 + $urandom % 19'h7FF00), 5'($urandom % 20), 8'h00, 1);
		scen(1, 0, 1, 0, 19'(256 + $urandom % 1752), 5'($urandom % 20), 8'(1 + $urandom % 250), 1);
		scen(1, 1, 0, 1, 19'($urandom % 256), 5'h13, 8'hFA, 1);
		scen(1, 0, 1, 1, 19'h7D7, 5'h1F, 8'h00, 1);
		scen(0, 0, 0, 0, 19'h12345, 5'h03, 8'h00, 1);
		scen(0, 1, 1, 0, 19'h04000, 5'(20 + $urandom % 11), 8'h00, 0);
		scen(1, 1, 1, 0, 19'h7D8, 5'h02, 8'h01, 0);
		scen(1, 1, 0, 1, 19'h800, 5'h02, 8'h01, 0);
		test_done;
	end
endmodule // testbench
`default_nettype wire
